// ### include/amcs_if.sv
// Serial control port and pins between host and converter control
`timescale 1ns/100ps
interface amcs_if;
    logic sclk;
    logic csel_n;
    logic sdata;
    logic chip_reset_low_pin;
    logic power_down_pin;
    modport dev (input sclk, input csel_n, input sdata, input chip_reset_low_pin, input power_down_pin);
    modport host (output sclk, output csel_n, output sdata, output chip_reset_low_pin, output power_down_pin);
endinterface

// ### include/amcs_pkg.sv
// Package of constants shared by the converter control ends
// Behaviour
// - Device timing uses rising clock edges only
// - Reset by pin pulse low or write 0x00=0x0001
// - Power down by pin high or 0x0F=0x0200
// - Active by pin low or 0x0F=0x0000
// - Host start-up order: reset, down, phase, mode, up, inputs
// - Phase register written only while down, before mode
// - Mode change: down, mode, up, reselect inputs
// - Register 0x31: mode upper byte, divider lower
// - Channel sample rate is clock over divider
// - Input selection applies immediately, no power down
// - Input bytes one-hot; quad assigns channels in order
// - Dual: 0x3A channel one, 0x3B channel two
// - Single: all four bytes equal one-hot
package amcs_pkg;
    // ==================================================
    // Register offsets
    localparam logic [7:0] REG_SOFT_RESET = 8'h00;
    localparam logic [7:0] REG_POWER_STATE = 8'h0f;
    localparam logic [7:0] REG_MODE_DIV = 8'h31;
    localparam logic [7:0] REG_INSEL_LOW = 8'h3a;
    localparam logic [7:0] REG_INSEL_HIGH = 8'h3b;
    localparam logic [7:0] REG_PHASE_CFG = 8'h42;
    // ==================================================
    // Register values
    localparam logic [15:0] VAL_SOFT_RESET = 16'h0001;
    localparam logic [15:0] VAL_POWER_DOWN = 16'h0200;
    localparam logic [15:0] VAL_ACTIVE = 16'h0000;
    localparam logic [15:0] VAL_MODE_SINGLE = 16'h0001;
    localparam logic [15:0] VAL_MODE_DUAL = 16'h0102;
    localparam logic [15:0] VAL_MODE_QUAD = 16'h0204;
    localparam logic [15:0] VAL_INSEL_RST = 16'h0202;
    localparam logic [15:0] VAL_PHASE_RST = 16'h0000;
    localparam logic [7:0] MODE_SINGLE = 8'h00;
    localparam logic [7:0] MODE_DUAL = 8'h01;
    localparam logic [7:0] MODE_QUAD = 8'h02;
    // ==================================================
    // Serial frame
    localparam int FRAME_BITS = 24;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [3:0] SCLK_HALF = 4'h2;
    // ==================================================
    // Host register map, AXI4-Lite byte addresses
    localparam logic [3:0] HA_CMD = 4'h0;
    localparam logic [3:0] HA_STATUS = 4'h4;
    localparam logic [3:0] HA_PINS = 4'h8;
    localparam logic [3:0] HA_RDATA = 4'hc;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### logic/amcs_device.sv
// Converter control end: serial register port, power, mode and input routing
`timescale 1ns/100ps
module amcs_device
(
    // Clock, reset, enable
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // Control link
    amcs_if.dev LINK,
    // Converter state
    output logic POWERED_DOWN_O,
    output logic [7:0] MODE_O,
    output logic [7:0] DIVIDER_O,
    output logic [15:0] INSEL_LOW_O,
    output logic [15:0] INSEL_HIGH_O,
    output logic [15:0] PHASE_CFG_O,
    output logic SAMPLE_STROBE_O,
    output logic [3:0] CH_INPUT_O [4]
);
    logic sclk_d_r;
    logic [4:0] bit_cnt_r;
    logic [23:0] shift_r;
    logic frame_done;
    logic [7:0] addr;
    logic [15:0] data;
    logic rst_pin_d_r;
    logic soft_rst;
    logic pin_rst;
    logic pin_pd_d_r;
    logic [7:0] div_cnt_r;
    logic [15:0] mode_div_r;

    // Shift on rising serial clock, 24th bit completes the frame
    assign frame_done = !LINK.csel_n && LINK.sclk && !sclk_d_r && bit_cnt_r == amcs_pkg::FRAME_LAST;
    assign addr = shift_r[22:15];
    assign data = {shift_r[14:0], LINK.sdata};
    assign soft_rst = frame_done && addr == amcs_pkg::REG_SOFT_RESET && data == amcs_pkg::VAL_SOFT_RESET;
    // Pin holds reset while low and once more on its return high
    assign pin_rst = !LINK.chip_reset_low_pin || !rst_pin_d_r;

    // Serial receiver
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            sclk_d_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            shift_r <= 24'h000000;
        end
        else if (CE_I)
        begin
            sclk_d_r <= LINK.sclk;
            if (LINK.csel_n)
                bit_cnt_r <= 5'h00;
            else if (LINK.sclk && !sclk_d_r)
            begin
                shift_r <= {shift_r[22:0], LINK.sdata};
                bit_cnt_r <= frame_done ? 5'h00 : bit_cnt_r + 5'h01;
            end
        end
    end

    // Reset pin edge: reset also applies on return high after a low pulse
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
            rst_pin_d_r <= 1'b1;
        else if (CE_I)
            rst_pin_d_r <= LINK.chip_reset_low_pin;
    end

    // Register file, cleared by pin pulse or soft reset command
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            mode_div_r <= amcs_pkg::VAL_MODE_SINGLE;
            INSEL_LOW_O <= amcs_pkg::VAL_INSEL_RST;
            INSEL_HIGH_O <= amcs_pkg::VAL_INSEL_RST;
            PHASE_CFG_O <= amcs_pkg::VAL_PHASE_RST;
        end
        else if (CE_I)
        begin
            if (pin_rst || soft_rst)
            begin
                mode_div_r <= amcs_pkg::VAL_MODE_SINGLE;
                INSEL_LOW_O <= amcs_pkg::VAL_INSEL_RST;
                INSEL_HIGH_O <= amcs_pkg::VAL_INSEL_RST;
                PHASE_CFG_O <= amcs_pkg::VAL_PHASE_RST;
            end
            else if (frame_done)
            begin
                unique case (addr)
                    // Mode writes only taken while down: sync routines need it
                    amcs_pkg::REG_MODE_DIV:
                        if (POWERED_DOWN_O)
                            mode_div_r <= data;
                    // Routing takes effect at end of frame in any state
                    amcs_pkg::REG_INSEL_LOW: INSEL_LOW_O <= data;
                    amcs_pkg::REG_INSEL_HIGH: INSEL_HIGH_O <= data;
                    amcs_pkg::REG_PHASE_CFG:
                        if (POWERED_DOWN_O)
                            PHASE_CFG_O <= data;
                    default: ;
                endcase
            end
        end
    end

    // Power state: pin edges and register writes both steer it
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pin_pd_d_r <= 1'b0;
            POWERED_DOWN_O <= 1'b0;
        end
        else if (CE_I)
        begin
            pin_pd_d_r <= LINK.power_down_pin;
            if (LINK.power_down_pin && !pin_pd_d_r)
                POWERED_DOWN_O <= 1'b1;
            else if (!LINK.power_down_pin && pin_pd_d_r)
                POWERED_DOWN_O <= 1'b0;
            else if (frame_done && addr == amcs_pkg::REG_POWER_STATE)
                POWERED_DOWN_O <= (data == amcs_pkg::VAL_POWER_DOWN) ? 1'b1 : (data == amcs_pkg::VAL_ACTIVE) ? 1'b0 : POWERED_DOWN_O;
            else if (pin_rst || soft_rst)
                POWERED_DOWN_O <= LINK.power_down_pin;
        end
    end

    // Mode and divider outputs
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            MODE_O <= amcs_pkg::MODE_SINGLE;
            DIVIDER_O <= amcs_pkg::VAL_MODE_SINGLE[7:0];
        end
        else if (CE_I)
        begin
            MODE_O <= mode_div_r[15:8];
            DIVIDER_O <= mode_div_r[7:0];
        end
    end

    // Channel sample strobe: rising edges only, clock over divider
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            div_cnt_r <= 8'h00;
            SAMPLE_STROBE_O <= 1'b0;
        end
        else if (CE_I)
        begin
            if (POWERED_DOWN_O || div_cnt_r + 8'h01 >= DIVIDER_O)
                div_cnt_r <= 8'h00;
            else
                div_cnt_r <= div_cnt_r + 8'h01;
            SAMPLE_STROBE_O <= !POWERED_DOWN_O && div_cnt_r == 8'h00;
        end
    end

    // Per-channel input, one-hot byte to input number 1..4, 0 if invalid
    function automatic logic [3:0] dec_in(input logic [7:0] b);
        unique case (b)
            8'h02: dec_in = 4'h1;
            8'h04: dec_in = 4'h2;
            8'h08: dec_in = 4'h3;
            8'h10: dec_in = 4'h4;
            default: dec_in = 4'h0;
        endcase
    endfunction

    // Byte use follows mode: quad in order, dual per register, single from 0x3A upper byte only
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
            for (int i = 0; i < 4; i++)
                CH_INPUT_O[i] <= 4'h0;
        else if (CE_I)
        begin
            CH_INPUT_O[0] <= dec_in(INSEL_LOW_O[15:8]);
            CH_INPUT_O[1] <= (MODE_O == amcs_pkg::MODE_SINGLE) ? 4'h0 :
                             (MODE_O == amcs_pkg::MODE_DUAL) ? dec_in(INSEL_HIGH_O[15:8]) :
                             dec_in(INSEL_LOW_O[7:0]);
            CH_INPUT_O[2] <= (MODE_O == amcs_pkg::MODE_QUAD) ? dec_in(INSEL_HIGH_O[15:8]) : 4'h0;
            CH_INPUT_O[3] <= (MODE_O == amcs_pkg::MODE_QUAD) ? dec_in(INSEL_HIGH_O[7:0]) : 4'h0;
        end
    end
endmodule

// ### logic/amcs_host.sv
// Host end: AXI4-Lite command registers driving serial frames and pins
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
module amcs_host
(
    // Clock, reset, enable
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // AXI4-Lite slave
    input wire logic [3:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [3:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    // Control link
    amcs_if.host LINK
);
    logic aw_ok_r;
    logic w_ok_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic busy_r;
    logic [23:0] shift_r;
    logic [4:0] bits_r;
    logic [3:0] half_r;
    logic [1:0] pins_r;
    logic wr_go;

    assign wr_go = aw_ok_r && w_ok_r && !BVALID_O;

    // Write channels taken in either order, one write at a time
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            BVALID_O <= 1'b0;
            BRESP_O <= amcs_pkg::RESP_OKAY;
        end
        else if (CE_I)
        begin
            if (AWVALID_I && AWREADY_O)
            begin
                aw_ok_r <= 1'b1;
                aw_addr_r <= AWADDR_I;
            end
            if (WVALID_I && WREADY_O)
            begin
                w_ok_r <= 1'b1;
                w_data_r <= WDATA_I;
                w_strb_r <= WSTRB_I;
            end
            if (wr_go)
            begin
                aw_ok_r <= 1'b0;
                w_ok_r <= 1'b0;
                BVALID_O <= 1'b1;
                // Command refused while a frame is still shifting
                BRESP_O <= (aw_addr_r == amcs_pkg::HA_CMD && busy_r) ? amcs_pkg::RESP_SLVERR :
                           (aw_addr_r == amcs_pkg::HA_CMD || aw_addr_r == amcs_pkg::HA_PINS) ?
                           amcs_pkg::RESP_OKAY : amcs_pkg::RESP_SLVERR;
            end
            else if (BVALID_O && BREADY_I)
                BVALID_O <= 1'b0;
        end
    end

    // Ready levels registered so outputs come from flops
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            AWREADY_O <= 1'b0;
            WREADY_O <= 1'b0;
        end
        else if (CE_I)
        begin
            AWREADY_O <= !aw_ok_r && !(AWVALID_I && AWREADY_O) && !BVALID_O;
            WREADY_O <= !w_ok_r && !(WVALID_I && WREADY_O) && !BVALID_O;
        end
    end

    // Read channel: status shows frame busy, pins word reads back the pin register
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ARREADY_O <= 1'b0;
            RVALID_O <= 1'b0;
            RDATA_O <= 32'h00000000;
            RRESP_O <= amcs_pkg::RESP_OKAY;
        end
        else if (CE_I)
        begin
            ARREADY_O <= !RVALID_O && !(ARVALID_I && ARREADY_O);
            if (ARVALID_I && ARREADY_O)
            begin
                RVALID_O <= 1'b1;
                RRESP_O <= amcs_pkg::RESP_OKAY;
                unique case (ARADDR_I)
                    amcs_pkg::HA_CMD: RDATA_O <= {8'h00, shift_r};
                    amcs_pkg::HA_STATUS: RDATA_O <= {31'h00000000, busy_r};
                    amcs_pkg::HA_PINS: RDATA_O <= {30'h00000000, pins_r};
                    default:
                    begin
                        RDATA_O <= 32'h00000000;
                        RRESP_O <= amcs_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (RVALID_O && RREADY_I)
                RVALID_O <= 1'b0;
        end
    end

    // Pins: bit0 drives reset low, bit1 drives power down high
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
            pins_r <= 2'h0;
        else if (CE_I && wr_go && aw_addr_r == amcs_pkg::HA_PINS && w_strb_r[0])
            pins_r <= w_data_r[1:0];
    end

    // Serial frame: address byte then 16-bit data, MSB first
    // Software sequences start-up and mode changes
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            busy_r <= 1'b0;
            shift_r <= 24'h000000;
            bits_r <= 5'h00;
            half_r <= 4'h0;
            LINK.sclk <= 1'b0;
            LINK.csel_n <= 1'b1;
            LINK.sdata <= 1'b0;
        end
        else if (CE_I)
        begin
            if (!busy_r && wr_go && aw_addr_r == amcs_pkg::HA_CMD)
            begin
                busy_r <= 1'b1;
                shift_r <= w_data_r[23:0];
                bits_r <= 5'h00;
                half_r <= 4'h0;
                LINK.csel_n <= 1'b0;
                LINK.sdata <= w_data_r[23];
            end
            else if (busy_r)
            begin
                if (half_r == amcs_pkg::SCLK_HALF)
                begin
                    half_r <= 4'h0;
                    LINK.sclk <= !LINK.sclk;
                    if (LINK.sclk)
                    begin
                        if (bits_r == amcs_pkg::FRAME_LAST)
                        begin
                            busy_r <= 1'b0;
                            LINK.csel_n <= 1'b1;
                        end
                        else
                        begin
                            bits_r <= bits_r + 5'h01;
                            shift_r <= {shift_r[22:0], 1'b0};
                            LINK.sdata <= shift_r[22];
                        end
                    end
                end
                else
                    half_r <= half_r + 4'h1;
            end
        end
    end

    // Pin levels to the link
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            LINK.chip_reset_low_pin <= 1'b1;
            LINK.power_down_pin <= 1'b0;
        end
        else if (CE_I)
        begin
            LINK.chip_reset_low_pin <= !pins_r[0];
            LINK.power_down_pin <= pins_r[1];
        end
    end
endmodule

// ### testbench/amcs_link_sva.sv
// Link and converter state assertions for the control pair
`timescale 1ns/100ps
module amcs_link_sva
(
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Control link
    input wire logic sclk,
    input wire logic csel_n,
    input wire logic sdata,
    input wire logic chip_reset_low_pin,
    input wire logic power_down_pin,
    // Converter state
    input wire logic POWERED_DOWN_O,
    input wire logic [7:0] MODE_O,
    input wire logic [7:0] DIVIDER_O,
    input wire logic [15:0] INSEL_LOW_O,
    input wire logic SAMPLE_STROBE_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    logic sclk_q_r;
    logic [5:0] bit_cnt_r;
    // ==================================================
    // Helper: serial clock rises inside the open frame
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            sclk_q_r <= 1'b0;
            bit_cnt_r <= 6'h00;
        end
        else
        begin
            sclk_q_r <= sclk;
            if (csel_n)
                bit_cnt_r <= 6'h00;
            else if (sclk && !sclk_q_r)
                bit_cnt_r <= bit_cnt_r + 6'h01;
        end
    end
    // ==================================================
    // Properties
    sequence s_quiet_3;
        !SAMPLE_STROBE_O [*3];
    endsequence
    property p_idle_low;
        csel_n && $past(csel_n) |-> !sclk;
    endproperty
    property p_frame_len;
        $rose(csel_n) |-> bit_cnt_r == 6'h18;
    endproperty
    property p_data_hold;
        $rose(sclk) && !csel_n |=> $stable(sdata);
    endproperty
    property p_pd_enter;
        $rose(power_down_pin) |-> ##[1:3] POWERED_DOWN_O;
    endproperty
    property p_pd_leave;
        $fell(power_down_pin) |-> ##[1:3] !POWERED_DOWN_O;
    endproperty
    property p_pin_reset;
        $fell(chip_reset_low_pin) |-> ##[1:3] (MODE_O == 8'h00 && DIVIDER_O == 8'h01 && INSEL_LOW_O == 16'h0202);
    endproperty
    // Power down may withhold the next strobe, so it also ends the sequence
    property p_quad_rate;
        SAMPLE_STROBE_O && DIVIDER_O == 8'h04 |=> s_quiet_3 ##1 (SAMPLE_STROBE_O || POWERED_DOWN_O);
    endproperty
    property p_no_strobe_down;
        POWERED_DOWN_O && $past(POWERED_DOWN_O) |-> !SAMPLE_STROBE_O;
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("serial clock moved outside a frame");
    a_frame_len: assert property (p_frame_len)
        else $error("frame did not carry 24 bits");
    a_data_hold: assert property (p_data_hold)
        else $error("serial data moved just after sampling");
    a_pd_enter: assert property (p_pd_enter)
        else $error("power down pin not obeyed");
    a_pd_leave: assert property (p_pd_leave)
        else $error("power up pin not obeyed");
    a_pin_reset: assert property (p_pin_reset)
        else $error("reset pin did not restore defaults");
    a_quad_rate: assert property (p_quad_rate)
        else $error("quad strobe spacing wrong");
    a_no_strobe_down: assert property (p_no_strobe_down)
        else $error("strobe while powered down");
endmodule

// ### testbench/amcs_test.sv
// Self-checking bench for the host and converter control pair
`timescale 1ns/100ps
module amcs_test;
    // ==================================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] awaddr = 4'h0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [3:0] araddr = 4'h0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pd_o, strobe;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] mode, divider;
    logic [15:0] insel_lo, insel_hi, phase;
    logic [3:0] ch_input [4];
    int bad_count = 0;
    int compares = 0;
    // Mode table: mode word, input words, channel inputs, strobes in 40 cycles
    logic [15:0] t_mode [3] = '{16'h0102, 16'h0204, 16'h0001};
    logic [15:0] t_lo [3] = '{16'h0202, 16'h1008, 16'h1010};
    logic [15:0] t_hi [3] = '{16'h0808, 16'h0402, 16'h1010};
    logic [3:0] t_ch0 [3] = '{4'h1, 4'h4, 4'h4};
    logic [3:0] t_ch1 [3] = '{4'h3, 4'h3, 4'h4};
    int t_rate [3] = '{20, 10, 40};
    amcs_if link_if ();
    // ==================================================
    // Design pair and checker
    amcs_host amcs_host_i (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(1'b1), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
        .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hf), .WVALID_I(wvalid), .WREADY_O(wready),
        .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
        .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
        .LINK(link_if.host));
    amcs_device amcs_device_i (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(1'b1), .LINK(link_if.dev),
        .POWERED_DOWN_O(pd_o), .MODE_O(mode), .DIVIDER_O(divider), .INSEL_LOW_O(insel_lo),
        .INSEL_HIGH_O(insel_hi), .PHASE_CFG_O(phase), .SAMPLE_STROBE_O(strobe), .CH_INPUT_O(ch_input));
    amcs_link_sva amcs_link_sva_i (.CLK_SYS_I(clk), .RST_I(rst), .sclk(link_if.sclk), .csel_n(link_if.csel_n),
        .sdata(link_if.sdata), .chip_reset_low_pin(link_if.chip_reset_low_pin),
        .power_down_pin(link_if.power_down_pin), .POWERED_DOWN_O(pd_o), .MODE_O(mode), .DIVIDER_O(divider),
        .INSEL_LOW_O(insel_lo), .SAMPLE_STROBE_O(strobe));
    // 125 MHz system clock
    initial
    begin
        forever #4 clk = ~clk;
    end
    // ==================================================
    // Reporting
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask
    // A hung handshake ends the run at once
    task automatic hang(input string name);
        $display("[FAIL] %s expected answer seen timeout", name);
        bad_count++;
        final_report();
    endtask
    // ==================================================
    // AXI4-Lite master: valid held until its own ready edge
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        int n;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        if (n == 100)
            hang("write response");
        chk("write response", {30'h0, exp_resp}, {30'h0, bresp});
    endtask
    task automatic axi_read(input logic [3:0] a, input logic [1:0] exp_resp, output logic [31:0] d);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        d = rdata;
        rready <= 1'b0;
        if (n == 100)
            hang("read response");
        chk("read response", {30'h0, exp_resp}, {30'h0, rresp});
    endtask
    // Poll busy, then allow the device its update latency
    task automatic wait_idle();
        logic [31:0] st;
        int n;
        for (n = 0; n < 200; n++)
        begin
            axi_read(amcs_pkg::HA_STATUS, amcs_pkg::RESP_OKAY, st);
            if (st[0] === 1'b0)
                break;
        end
        if (n == 200)
            hang("frame busy");
        repeat (3) @(posedge clk);
    endtask
    task automatic send_cmd(input logic [7:0] a, input logic [15:0] d);
        axi_write(amcs_pkg::HA_CMD, {8'h00, a, d}, amcs_pkg::RESP_OKAY);
        wait_idle();
    endtask
    task automatic set_pins(input logic [31:0] v);
        axi_write(amcs_pkg::HA_PINS, v, amcs_pkg::RESP_OKAY);
        repeat (4) @(posedge clk);
    endtask
    task automatic strobes(input int exp);
        int n;
        n = 0;
        repeat (40)
        begin
            @(posedge clk);
            if (strobe === 1'b1)
                n++;
        end
        chk("strobe count", exp, n);
    endtask
    task automatic chk_defaults();
        chk("mode", 32'h0, {24'h0, mode});
        chk("divider", 32'h1, {24'h0, divider});
        chk("insel low", 32'h0202, {16'h0, insel_lo});
        chk("insel high", 32'h0202, {16'h0, insel_hi});
        chk("phase", 32'h0, {16'h0, phase});
    endtask
    // ==================================================
    // Main sequence: start-up, each mode by command or pin, then resets
    initial
    begin
        int i;
        logic [31:0] rd;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk_defaults();
        chk("powered down", 32'h0, {31'h0, pd_o});
        send_cmd(8'h00, 16'h0001);
        for (i = 0; i < 3; i++)
        begin
            if (i == 1)
                set_pins(32'h2);
            else
                send_cmd(8'h0f, 16'h0200);
            chk("powered down", 32'h1, {31'h0, pd_o});
            strobes(0);
            if (i == 0)
                send_cmd(8'h42, 16'h0005);
            send_cmd(8'h31, t_mode[i]);
            chk("mode", {24'h0, t_mode[i][15:8]}, {24'h0, mode});
            chk("divider", {24'h0, t_mode[i][7:0]}, {24'h0, divider});
            if (i == 1)
                set_pins(32'h0);
            else
                send_cmd(8'h0f, 16'h0000);
            chk("powered down", 32'h0, {31'h0, pd_o});
            send_cmd(8'h3a, t_lo[i]);
            send_cmd(8'h3b, t_hi[i]);
            chk("channel one", {28'h0, t_ch0[i]}, {28'h0, ch_input[0]});
            if (i < 2)
                chk("channel two", {28'h0, t_ch1[i]}, {28'h0, ch_input[1]});
            if (i == 1)
            begin
                chk("channel three", 32'h2, {28'h0, ch_input[2]});
                chk("channel four", 32'h1, {28'h0, ch_input[3]});
            end
            strobes(t_rate[i]);
        end
        chk("phase", 32'h5, {16'h0, phase});
        // Mode word is only taken while powered down
        send_cmd(8'h31, 16'h0204);
        chk("mode", 32'h0, {24'h0, mode});
        send_cmd(8'h3a, 16'h0404);
        send_cmd(8'h3b, 16'h0404);
        chk("channel one", 32'h2, {28'h0, ch_input[0]});
        // Second order while a frame runs is refused and dropped
        axi_write(amcs_pkg::HA_CMD, 32'h003b0808, amcs_pkg::RESP_OKAY);
        axi_write(amcs_pkg::HA_CMD, 32'h003a1010, amcs_pkg::RESP_SLVERR);
        wait_idle();
        chk("insel high", 32'h0808, {16'h0, insel_hi});
        chk("insel low", 32'h0404, {16'h0, insel_lo});
        send_cmd(8'h00, 16'h0001);
        chk_defaults();
        send_cmd(8'h3a, 16'h1010);
        set_pins(32'h1);
        axi_read(amcs_pkg::HA_PINS, amcs_pkg::RESP_OKAY, rd);
        chk("pins", 32'h1, rd);
        // Unmapped word: refused both ways
        axi_read(4'hc, amcs_pkg::RESP_SLVERR, rd);
        chk("unmapped read", 32'h0, rd);
        axi_write(4'hc, 32'h0, amcs_pkg::RESP_SLVERR);
        set_pins(32'h0);
        chk_defaults();
        final_report();
    end
endmodule
